// *** uv_stage_bank.sv ***
`timescale 1ns/100ps
`include "uv_defines.svh"
// Overview of operation
// - Four independent stages, own outputs and counters.
// - Magnitude select 0 P-P,1 P-E,2 third,3 fourth.
// - Eight parameter sets, chosen by common input.
// - Instant, definite time or inverse time operation.
// - Internal low-voltage block plus external block input.
// - Drive start, trip and blocked outputs.
// - Time-stamped event on every output edge.
// - Instant mode: start and trip share event.
// - Time stamps count whole milliseconds.
// - Clearable counters of start, trip, blocked.
// - Compare RMS line and phase values each update.
// - Keep 20 ms average ending 20 ms before.
// - Two-line wiring uses first two channels only.
// - Third channel selectable only in two-line wiring.
// - Setting changes act while running, no restart.
// - Release at 103 percent of pick-up level.
// - Low-voltage block holds until all above pick-up.
// - Start only while no block is active.
module uv_stage_bank #(
   parameter int NSTG = 4,
   parameter int MS_CYC = `UV_MS_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input uv_pkg::meas_t meas,
   input wire logic meas_valid,
   input wire logic [2:0] set_group,
   input wire logic [3:0] ext_block,
   output logic [3:0] start,
   output logic [3:0] trip,
   output logic [3:0] blocked,
   output uv_pkg::evt_t [3:0] evt,
   output logic irq
);
   import uv_pkg::*;

   function automatic logic [15:0] min2(input logic [15:0] a, input logic [15:0] b);
      return (a < b) ? a : b;
   endfunction : min2

   // Returns {usable, smallest selected magnitude}; the smallest one below
   // the level means any one of them is below it.
   function automatic logic [16:0] sel_mag(input logic [1:0] sel, input logic wir,
                                           input meas_t m);
      logic [15:0] pp;
      logic [15:0] pe;
      pp = wir ? min2(m.ll[0], m.ll[1]) : min2(min2(m.ll[0], m.ll[1]), m.ll[2]);
      pe = wir ? min2(m.ln[0], m.ln[1]) : min2(min2(m.ln[0], m.ln[1]), m.ln[2]);
      case (mag_sel_t'(sel))
         sel_pp: return {1'b1, pp};
         sel_pe: return {1'b1, pe};
         sel_third: return {wir, m.ch3};
         sel_fourth: return {1'b1, m.ch4};
         default: return 17'h00000;
      endcase
   endfunction : sel_mag

   // ==========================================================
   // Millisecond time base.
   logic [31:0] tick_cnt_q;
   logic ms_tick;
   logic [31:0] stamp_q;

   assign ms_tick = (tick_cnt_q == 32'(MS_CYC - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_q <= 32'h0;
         stamp_q <= 32'h0;
      end else if (ms_tick) begin
         tick_cnt_q <= 32'h0;
         stamp_q <= stamp_q + 32'h1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h1;
      end
   end

   // ==========================================================
   // External block pins.
   logic [3:0] ext_m_q;
   logic [3:0] ext_s_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_m_q <= 4'h0;
         ext_s_q <= 4'h0;
      end else begin
         ext_m_q <= ext_block;
         ext_s_q <= ext_m_q;
      end
   end

   // ==========================================================
   // Register bus.
   logic wr_en;
   logic wiring_q;
   logic [3:0] clr_q;
   logic [11:0] ists_q;
   logic [11:0] imsk_q;
   logic [11:0] ev_set;
   logic [31:0] set_a_q [32];
   logic [31:0] set_b_q [32];
   logic set_hit;
   logic [4:0] set_idx;

   assign wr_en = psel & penable & pwrite;
   assign set_hit = (paddr[11:8] == `UV_SET_BASE);
   assign set_idx = paddr[7:3];
   assign pready = 1'b1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wiring_q <= 1'b0;
         clr_q <= 4'h0;
         imsk_q <= 12'h000;
      end else begin
         clr_q <= 4'h0;
         if (wr_en && paddr == `UV_CTRL_OFS) begin
            wiring_q <= pwdata[`UV_CTRL_WIRING];
            clr_q <= pwdata[`UV_CTRL_CLR_LSB +: 4];
         end
         if (wr_en && paddr == `UV_IMSK_OFS) begin
            imsk_q <= pwdata[11:0];
         end
      end
   end

   // Set bits win over a simultaneous write-one-to-clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ists_q <= 12'h000;
      end else if (wr_en && paddr == `UV_ISTS_OFS) begin
         ists_q <= (ists_q & ~pwdata[11:0]) | ev_set;
      end else begin
         ists_q <= ists_q | ev_set;
      end
   end

   assign irq = |(ists_q & imsk_q);

   // Parameter sets may be rewritten at any time; the stages read them live.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 32; i++) begin
            set_a_q[i] <= {`UV_BLOCK_RST, `UV_PICKUP_RST};
            set_b_q[i] <= {16'h0000, `UV_DELAY_RST};
         end
      end else if (wr_en && set_hit) begin
         if (paddr[2]) begin
            set_b_q[set_idx] <= pwdata;
         end else begin
            set_a_q[set_idx] <= pwdata;
         end
      end
   end

   // ==========================================================
   // Stage logic.
   logic [15:0] mag_c [4];
   logic [3:0] ok_c;
   logic [15:0] pk_c [4];
   logic [15:0] bl_c [4];
   logic [15:0] dl_c [4];
   logic [1:0] sel_c [4];
   logic [3:0] idmt_c;
   logic [16:0] rel_c [4];
   logic [3:0] pick_q;
   logic [3:0] iblk_q;
   logic [31:0] acc_q [4];
   logic [3:0] start_d;
   logic [3:0] trip_d;
   logic [3:0] blk_d;
   logic [3:0] start_q;
   logic [3:0] trip_q;
   logic [3:0] blk_q;
   logic [15:0] hist_q [4][`UV_HIST_SAMPLES];
   logic [15:0] pf_q [4];
   logic [`UV_CNT_W-1:0] cnt_q [4][3];
   evt_t [3:0] evt_q;

   always_comb begin
      for (int s = 0; s < NSTG; s++) begin
         logic [4:0] ix;
         logic [16:0] sm;
         logic done;
         ix = {2'(s), set_group};
         sm = sel_mag(set_b_q[ix][`UV_SEL_LSB +: 2], wiring_q, meas);
         ok_c[s] = sm[16];
         mag_c[s] = sm[15:0];
         pk_c[s] = set_a_q[ix][15:0];
         bl_c[s] = set_a_q[ix][31:16];
         dl_c[s] = set_b_q[ix][15:0];
         sel_c[s] = set_b_q[ix][`UV_SEL_LSB +: 2];
         idmt_c[s] = set_b_q[ix][`UV_TYPE_BIT];
         rel_c[s] = 17'((24'(pk_c[s]) * `UV_HYST_PCT) / `UV_PCT_BASE);
         blk_d[s] = iblk_q[s] | ext_s_q[s];
         start_d[s] = pick_q[s] & ~blk_d[s];
         done = idmt_c[s] ? (acc_q[s] >= 32'(dl_c[s]) * 32'(pk_c[s]))
                          : (acc_q[s] >= 32'(dl_c[s]));
         if (!start_d[s]) begin
            trip_d[s] = 1'b0;
         end else if (dl_c[s] == 16'h0000) begin
            trip_d[s] = 1'b1;
         end else begin
            trip_d[s] = trip_q[s] | done;
         end
      end
   end

   // Pick-up and low-voltage block move only on a fresh measurement.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pick_q <= 4'h0;
         iblk_q <= 4'h0;
      end else if (meas_valid) begin
         for (int s = 0; s < NSTG; s++) begin
            if (!ok_c[s]) begin
               pick_q[s] <= 1'b0;
            end else if (!pick_q[s]) begin
               pick_q[s] <= (mag_c[s] < pk_c[s]);
            end else if (17'(mag_c[s]) >= rel_c[s]) begin
               pick_q[s] <= 1'b0;
            end
            if (bl_c[s] == 16'h0000) begin
               iblk_q[s] <= 1'b0;
            end else if (ok_c[s] && mag_c[s] < bl_c[s]) begin
               iblk_q[s] <= 1'b1;
            end else if (mag_c[s] > pk_c[s]) begin
               iblk_q[s] <= 1'b0;
            end
         end
      end
   end

   // Inverse time integrates the voltage deficit each millisecond and trips
   // at delay times pick-up; a deeper dip therefore trips sooner.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int s = 0; s < 4; s++) begin
            acc_q[s] <= 32'h0;
         end
      end else begin
         for (int s = 0; s < NSTG; s++) begin
            if (!start_d[s]) begin
               acc_q[s] <= 32'h0;
            end else if (ms_tick && !trip_q[s]) begin
               if (idmt_c[s]) begin
                  acc_q[s] <= acc_q[s] + 32'(pk_c[s] - min2(mag_c[s], pk_c[s]));
               end else begin
                  acc_q[s] <= acc_q[s] + 32'h1;
               end
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_q <= 4'h0;
         trip_q <= 4'h0;
         blk_q <= 4'h0;
         evt_q <= '0;
      end else begin
         start_q <= start_d;
         trip_q <= trip_d;
         blk_q <= blk_d;
         for (int s = 0; s < NSTG; s++) begin
            evt_q[s].start_chg <= start_d[s] ^ start_q[s];
            evt_q[s].trip_chg <= trip_d[s] ^ trip_q[s];
            evt_q[s].block_chg <= blk_d[s] ^ blk_q[s];
            evt_q[s].valid <= (start_d[s] ^ start_q[s]) | (trip_d[s] ^ trip_q[s])
                              | (blk_d[s] ^ blk_q[s]);
            evt_q[s].start <= start_d[s];
            evt_q[s].trip <= trip_d[s];
            evt_q[s].blocked <= blk_d[s];
            evt_q[s].stamp <= stamp_q;
         end
      end
   end

   assign start = start_q;
   assign trip = trip_q;
   assign blocked = blk_q;
   assign evt = evt_q;

   always_comb begin
      for (int s = 0; s < 4; s++) begin
         ev_set[s * 3] = start_d[s] & ~start_q[s];
         ev_set[s * 3 + 1] = trip_d[s] & ~trip_q[s];
         ev_set[s * 3 + 2] = blk_d[s] & ~blk_q[s];
      end
   end

   // Counters wrap; clear beats a same-cycle increment because software
   // asks for a fresh start.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int s = 0; s < 4; s++) begin
            for (int k = 0; k < 3; k++) begin
               cnt_q[s][k] <= '0;
            end
         end
      end else begin
         for (int s = 0; s < NSTG; s++) begin
            for (int k = 0; k < 3; k++) begin
               if (clr_q[s]) begin
                  cnt_q[s][k] <= '0;
               end else if (ev_set[s * 3 + k]) begin
                  cnt_q[s][k] <= cnt_q[s][k] + 1'b1;
               end
            end
         end
      end
   end

   // History holds eight 5 ms samples; the oldest four make the average.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int s = 0; s < 4; s++) begin
            pf_q[s] <= 16'h0;
            for (int h = 0; h < `UV_HIST_SAMPLES; h++) begin
               hist_q[s][h] <= 16'h0;
            end
         end
      end else begin
         for (int s = 0; s < NSTG; s++) begin
            if (meas_valid) begin
               hist_q[s][0] <= mag_c[s];
               for (int h = 1; h < `UV_HIST_SAMPLES; h++) begin
                  hist_q[s][h] <= hist_q[s][h - 1];
               end
            end
            if (ev_set[s * 3] || ev_set[s * 3 + 1]) begin
               pf_q[s] <= 16'((18'(hist_q[s][4]) + 18'(hist_q[s][5]) + 18'(hist_q[s][6])
                               + 18'(hist_q[s][7])) >> 2);
            end
         end
      end
   end

   always_comb begin
      logic [1:0] st;
      st = paddr[3:2];
      prdata = 32'h0;
      pslverr = 1'b0;
      if (set_hit) begin
         prdata = paddr[2] ? set_b_q[set_idx] : set_a_q[set_idx];
      end else if (paddr[11:8] != 4'h0) begin
         pslverr = psel & penable;
      end else if (paddr[7:4] == `UV_STAT_BASE) begin
         prdata = {pf_q[st], 13'h0, blk_q[st], trip_q[st], start_q[st]};
      end else if (paddr[7:4] == `UV_CNT_BASE) begin
         prdata = {2'h0, cnt_q[st][2], cnt_q[st][1], cnt_q[st][0]};
      end else begin
         case (paddr)
            `UV_CTRL_OFS: prdata = {31'h0, wiring_q};
            `UV_ISTS_OFS: prdata = {20'h0, ists_q};
            `UV_IMSK_OFS: prdata = {20'h0, imsk_q};
            `UV_TIME_OFS: prdata = stamp_q;
            default: pslverr = psel & penable;
         endcase
      end
   end

   // ==========================================================
   // Checks.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_start_not_blocked: assert property (start_q[0] |-> !blk_q[0])
      else $error("start with block active");
   chk_instant_trip_pair: assert property (
      $rose(start_q[3]) && dl_c[3] == 16'h0 && $stable(dl_c[3]) |-> $rose(trip_q[3]))
      else $error("instant trip not with start");
   chk_event_on_edge: assert property ($changed(trip_q[2]) |-> evt_q[2].valid
      && evt_q[2].trip_chg && evt_q[2].stamp == $past(stamp_q))
      else $error("trip edge without event");
   chk_irq_level: assert property (irq == |(ists_q & imsk_q))
      else $error("irq level wrong");
   chk_sts_sticky: assert property ($rose(start_q[0]) |-> ists_q[0])
      else $error("start status not set");
   chk_counter_clear: assert property (clr_q[0] |=> cnt_q[0][0] == '0)
      else $error("counter not cleared");
   chk_stamp_tick: assert property (ms_tick |=> stamp_q == $past(stamp_q) + 32'h1)
      else $error("stamp not advanced");
   chk_trip_needs_start: assert property (trip_q[0] |-> start_q[0])
      else $error("trip without start");
   chk_zero_block_level: assert property (
      meas_valid && bl_c[3] == 16'h0 |=> !iblk_q[3])
      else $error("block level zero still blocks");
endmodule : uv_stage_bank

// *** uv_defines.svh ***
`ifndef UV_DEFINES_SVH
`define UV_DEFINES_SVH
// ==========================================================
// Timing.
`define UV_CLK_NS 20
`define UV_MS_NS 1000000
`define UV_MS_CYC (`UV_MS_NS / `UV_CLK_NS)
`define UV_HIST_SAMPLES 8
`define UV_HYST_PCT 24'd103
`define UV_PCT_BASE 24'd100
// ==========================================================
// Register offsets.
`define UV_CTRL_OFS 12'h000
`define UV_ISTS_OFS 12'h004
`define UV_IMSK_OFS 12'h008
`define UV_TIME_OFS 12'h00c
`define UV_STAT_BASE 4'h1
`define UV_CNT_BASE 4'h2
`define UV_SET_BASE 4'h1
// ==========================================================
// Field positions and reset values.
`define UV_CTRL_WIRING 0
`define UV_CTRL_CLR_LSB 4
`define UV_SEL_LSB 16
`define UV_TYPE_BIT 18
`define UV_PICKUP_RST 16'h1770
`define UV_BLOCK_RST 16'h03e8
`define UV_DELAY_RST 16'h0028
`define UV_CNT_W 10
`endif

// *** uv_pkg.sv ***
package uv_pkg;
   typedef struct packed {
      logic [2:0][15:0] ll;
      logic [2:0][15:0] ln;
      logic [15:0] ch3;
      logic [15:0] ch4;
   } meas_t;
   typedef struct packed {
      logic valid;
      logic start_chg;
      logic trip_chg;
      logic block_chg;
      logic start;
      logic trip;
      logic blocked;
      logic [31:0] stamp;
   } evt_t;
   typedef enum logic [1:0] {sel_pp, sel_pe, sel_third, sel_fourth} mag_sel_t;
endpackage : uv_pkg

// *** uv_meas_model.sv ***
`timescale 1ns/100ps
// ==========================================================
// Measurement front end model.
module uv_meas_model #(
   parameter int PERIOD = 50
) (
   input wire logic pclk,
   input wire logic presetn,
   input uv_pkg::meas_t level,
   output uv_pkg::meas_t meas,
   output logic meas_valid
);
   import uv_pkg::*;
   int cnt_q;
   // RMS values hold between refreshes, as a real front end keeps its last result.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 0;
         meas <= '0;
         meas_valid <= 1'b0;
      end else begin
         meas_valid <= (cnt_q == PERIOD - 1);
         cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
         if (cnt_q == PERIOD - 1) begin
            meas <= level;
         end
      end
   end
endmodule : uv_meas_model

// *** undervoltage_protection_stage_tb.sv ***
`timescale 1ns/100ps
module undervoltage_protection_stage_tb;
   import uv_pkg::*;
   localparam int MS = 10;
   localparam int PER = 5 * MS;
   localparam logic [15:0] PICK = 16'h1770;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, meas_valid, irq, err, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, t0;
   logic [2:0] set_group;
   logic [3:0] ext_block, start, trip, blocked;
   logic [1:0] sel;
   logic wir;
   meas_t level, meas, m;
   evt_t [3:0] evt;
   evt_t last_evt;
   int fails, num_checks;

   uv_stage_bank #(.NSTG(4), .MS_CYC(MS)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .meas(meas), .meas_valid(meas_valid),
      .set_group(set_group), .ext_block(ext_block), .start(start), .trip(trip),
      .blocked(blocked), .evt(evt), .irq(irq));
   uv_meas_model #(.PERIOD(PER)) src (.pclk(pclk), .presetn(presetn), .level(level),
      .meas(meas), .meas_valid(meas_valid));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) if (evt[3].valid === 1'b1) last_evt <= evt[3];

   // ==========================================================
   // Shared tasks.
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) fails++;
   endtask : apb

   task automatic settle();
      repeat (2 * PER + 4) @(posedge pclk);
   endtask : settle

   function automatic logic exp_low(meas_t v, logic [1:0] s, logic w);
      logic [15:0] mn;
      mn = 16'hffff;
      for (int i = 0; i < 3; i++) begin
         if (i < 2 || !w) begin
            if (s == 2'd0 && v.ll[i] < mn) mn = v.ll[i];
            if (s == 2'd1 && v.ln[i] < mn) mn = v.ln[i];
         end
      end
      if (s == 2'd2 && w) mn = v.ch3;
      if (s == 2'd3) mn = v.ch4;
      return mn < PICK;
   endfunction : exp_low

   // Delayed trip on stage 0; the window allows for the phase of the ms tick.
   task automatic dt_run(input int ms);
      int n;
      level <= {8{16'd9000}};
      settle();
      level <= {8{16'd3000}};
      n = 0;
      while (start[0] !== 1'b1 && n < 4 * PER) begin
         @(negedge pclk);
         n++;
      end
      chk("start0", start[0], 1'b1);
      chk("trip0 early", trip[0], 1'b0);
      n = 0;
      while (trip[0] !== 1'b1 && n < 2000) begin
         @(negedge pclk);
         n++;
      end
      chk("dt window", (n >= (ms - 1) * MS) && (n <= ms * MS + 3), 1'b1);
   endtask : dt_run

   // ==========================================================
   // Main sequence.
   initial begin
      {psel, penable, pwrite, paddr, pwdata, set_group, ext_block} = '0;
      level = {8{16'd9000}};
      last_evt = '0;
      presetn = 1'b0;
      fails = 0;
      num_checks = 0;
      void'($urandom(32'h0ae16fe5));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk("outs reset", {start, trip, blocked}, 12'h000);
      apb(1'b0, 12'h100, 0);
      chk("set word a", rd, 32'h03e81770);
      apb(1'b0, 12'h104, 0);
      chk("set word b", rd, 32'h00000028);
      apb(1'b0, 12'h3f0, 0);
      chk("unmapped err", {31'd0, err}, 32'h1);
      chk("unmapped rd", rd, 32'h0);
      apb(1'b1, 12'h1c0, 32'h00001770); // stage 3 with low-voltage block off
      for (int i = 0; i < 16; i++) begin
         sel = 2'(i % 4);
         wir = (i == 4) ? 1'b1 : 1'($urandom_range(1, 0));
         apb(1'b1, 12'h000, {31'd0, wir});
         apb(1'b1, 12'h1c4, {14'd0, sel, 16'd0});
         level <= {8{16'd9000}};
         settle();
         last_evt <= '0;
         for (int k = 0; k < 8; k++) m[k * 16 +: 16] = 16'($urandom_range(9000, 3000));
         if (i == 1) m = {8{PICK}};
         if (i == 2) m = {8{PICK - 16'd1}};
         if (i == 4) m = {{7{16'd9000}}, 16'd100};
         level <= m;
         settle();
         e = exp_low(m, sel, wir);
         chk("start3", start[3], e);
         chk("trip3", trip[3], e);
         if (e) chk("evt pair", {last_evt.start_chg, last_evt.trip_chg}, 2'b11);
      end
      apb(1'b1, 12'h000, 0);
      apb(1'b1, 12'h1c4, 0);
      level <= {8{PICK - 16'd1}};
      settle();
      level <= {8{16'd6179}};
      settle();
      chk("hyst hold", start[3], 1'b1);
      level <= {8{16'd6180}};
      settle();
      chk("hyst release", start[3], 1'b0);
      ext_block <= 4'b0010;
      level <= {8{16'd500}};
      settle();
      chk("int block", {blocked[0], start[0]}, 2'b10);
      chk("ext block", {blocked[1], start[1]}, 2'b10);
      level <= {8{16'd3000}};
      settle();
      chk("block held", blocked[0], 1'b1);
      level <= {8{16'd7000}};
      settle();
      chk("block freed", blocked[0], 1'b0);
      ext_block <= 4'b0000;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk("ext free", blocked[1], 1'b0);
      apb(1'b1, 12'h000, 32'h10);
      apb(1'b1, 12'h004, 32'hfff);
      dt_run(40);
      apb(1'b0, 12'h020, 0);
      chk("counters", rd, 32'h00000401);
      apb(1'b0, 12'h010, 0);
      chk("status0", {29'd0, rd[2:0]}, 32'h3);
      apb(1'b0, 12'h004, 0);
      chk("irq status", rd, 32'h000006db);
      apb(1'b1, 12'h008, 32'h1);
      @(negedge pclk);
      chk("irq on", irq, 1'b1);
      apb(1'b1, 12'h004, 32'hfff);
      @(negedge pclk);
      chk("irq off", irq, 1'b0);
      apb(1'b1, 12'h000, 32'h10);
      repeat (2) @(posedge pclk);
      apb(1'b0, 12'h020, 0);
      chk("cnt clear", rd, 0);
      set_group <= 3'd1;
      apb(1'b1, 12'h10c, 32'h5);
      dt_run(5);
      apb(1'b0, 12'h00c, 0);
      t0 = rd;
      repeat (97) @(posedge pclk);
      apb(1'b0, 12'h00c, 0);
      chk("stamp ms", rd - t0, 32'd10);
      test_done();
   end

   initial begin
      repeat (30000) @(posedge pclk);
      fails++;
      test_done();
   end
endmodule : undervoltage_protection_stage_tb
